// [src/dws_pkg.sv]
// Package for the DAC waveform sequencer: constants, enums and carriers.
package dws_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DWS_DATA_W  = 16;
  localparam int DWS_DEPTH   = 2048;
  localparam int DWS_ADDR_W  = 11;
  localparam int DWS_CNT_W   = 12;
  localparam int DWS_RETX_W  = 16;
  localparam logic [DWS_CNT_W-1:0] DWS_HALF = 12'h400;
  localparam logic [DWS_CNT_W-1:0] DWS_FULL = 12'h800;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DWS_DATA_W-1:0] DWS_DAC_RST = 16'h0000;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    TRIG_CTR1 = 3'h0,
    TRIG_CTR2 = 3'h1,
    TRIG_CTR3 = 3'h2,
    TRIG_CTR5 = 3'h3,
    TRIG_EXT  = 3'h4,
    TRIG_REG  = 3'h5
  } dws_trig_t;

  typedef enum logic [1:0] {
    MODE_STREAM = 2'h0,
    MODE_CYCLIC = 2'h1,
    MODE_PROG   = 2'h2,
    MODE_PULSED = 2'h3
  } dws_mode_t;

  // Gray codes along idle -> run -> gap -> done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_GAP  = 2'b11,
    ST_DONE = 2'b10
  } dws_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic                  posted;
    dws_mode_t             mode;
    dws_trig_t             trigSel;
    logic                  trigEnable;
    logic                  halfFullReq;
    logic                  graceful_stop_bit;
    logic [DWS_RETX_W-1:0] burstCount;
    logic [DWS_RETX_W-1:0] gapCycles;
  } dws_cfg_t;

  typedef struct packed {
    logic                  sample_write_request;
    logic                  waveformError;
    logic                  sequenceDone;
    logic                  fifoEmpty;
    logic                  fifoFull;
    logic [DWS_CNT_W-1:0]  fifoLevel;
  } dws_stat_t;

endpackage

// [src/dws_sequencer.sv]
// DAC waveform sequencer: posted and immediate update of two DAC channels.
// Summary of operation
// [RULE1] Posted mode updates output only on trigger.
// [RULE2] Trigger from counters, external pin, or register.
// [RULE3] Write request visible as status and request.
// [RULE4] Request from not-full or under-half-full.
// [RULE5] Each trigger pops one sample, re-requests.
// [RULE6] Host streams samples for long waveforms.
// [RULE7] Short waveforms loaded once, replayed repeatedly.
// [RULE8] Empty at update halts and flags error.
// [RULE9] Cyclic end of buffer rewinds read pointer.
// [RULE10] Stop bit clear: replay until trigger disabled.
// [RULE11] Stop bit set: end after next rewind.
// [RULE12] Trigger disable stops at once, output held.
// [RULE13] Programmed cyclic counts rewinds then ends.
// [RULE14] Status bit shows sequence terminated.
// [RULE15] Pulsed: burst count, gap timer, restart.
// [RULE16] Cyclic modes only when buffer fits.
// [RULE17] FIFO holds up to 2048 samples.
// [RULE18] Immediate mode latch drives DAC directly.
// [RULE19] Posted latch write applied at next trigger.
// [RULE20] Error sticky until cleared, no auto-resume.
`timescale 1ns/10ps
module dws_sequencer
  import dws_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Configuration
  input  wire dws_cfg_t              cfg,
  input  wire logic                  start,
  input  wire logic                  clearError,
  input  wire logic                  fifoReset,
  // Trigger sources
  input  wire logic [3:0]            counterPulse_n,
  input  wire logic                  external_update_trigger_n,
  input  wire logic                  updateStrobe,
  // Host sample writes
  input  wire logic                  fifoWrite,
  input  wire logic                  latchWrite,
  input  wire logic                  channelSel,
  input  wire logic [DWS_DATA_W-1:0] sampleData,
  // Outputs
  output logic [DWS_DATA_W-1:0]      dacCode0,
  output logic [DWS_DATA_W-1:0]      dacCode1,
  output logic                       fifo_rewind_pulse_n,
  output dws_stat_t                  status
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    dws_state_t            st;
    logic [DWS_ADDR_W-1:0] wrPtr;
    logic [DWS_ADDR_W-1:0] rdPtr;
    logic [DWS_CNT_W-1:0]  level;
    logic [DWS_CNT_W-1:0]  stored;
    logic [DWS_CNT_W-1:0]  pos;
    logic [DWS_RETX_W-1:0] retx;
    logic [DWS_RETX_W-1:0] gap;
    logic [4:0]            trigHist;
    logic [DWS_DATA_W-1:0] latch0;
    logic [DWS_DATA_W-1:0] latch1;
    logic                  latchPend0;
    logic                  latchPend1;
    logic [DWS_DATA_W-1:0] dac0;
    logic [DWS_DATA_W-1:0] dac1;
    logic                  rewind_n;
    dws_stat_t             stat;
  } dws_reg_t;

  dws_reg_t                 cur_ff;
  dws_reg_t                 nxt_cur;
  logic [DWS_DATA_W:0]      mem [DWS_DEPTH];
  logic [DWS_DATA_W:0]      rdWord;
  logic [4:0]               trigNow;
  logic                     trigLevel;
  logic                     trigHit;
  logic                     cyclic;
  logic                     doWrite;

  assign rdWord = mem[cur_ff.rdPtr];
  assign cyclic = (cfg.mode != MODE_STREAM);
  // Writes are refused while full; in cyclic modes only before the run starts.
  assign doWrite = fifoWrite && (cur_ff.level != DWS_FULL) && !(cyclic && cur_ff.st != ST_IDLE);

  // Memory: channel bit stored beside each sample.
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[cur_ff.wrPtr] <= {channelSel, sampleData};  // see [RULE17]
    end
  end

  // Active-low trigger sources as active-high levels.
  assign trigNow = {updateStrobe, ~external_update_trigger_n, ~counterPulse_n[3], ~counterPulse_n[2],
                    ~counterPulse_n[1] & 1'b1};

  always_comb begin
    trigLevel = 1'b0;
    unique case (cfg.trigSel)  // see [RULE2]
      TRIG_CTR1: trigLevel = ~counterPulse_n[0];
      TRIG_CTR2: trigLevel = trigNow[0];
      TRIG_CTR3: trigLevel = trigNow[1];
      TRIG_CTR5: trigLevel = trigNow[2];
      TRIG_EXT:  trigLevel = trigNow[3];
      TRIG_REG:  trigLevel = trigNow[4];
      default:   trigLevel = 1'b0;
    endcase
  end

  // One update per assertion of the selected trigger (falling edge of an active-low pulse, rising edge of updateStrobe); a held level is one update.
  assign trigHit = cfg.trigEnable && trigLevel && !cur_ff.trigHist[0];  // see [RULE12]

  always_comb begin
    nxt_cur             = cur_ff;
    nxt_cur.trigHist    = {4'h0, trigLevel};
    nxt_cur.rewind_n    = 1'b1;

    if (doWrite) begin
      nxt_cur.wrPtr = cur_ff.wrPtr + 1'b1;
    end

    // Local latch path.
    if (latchWrite) begin
      if (!cfg.posted) begin
        if (channelSel) begin
          nxt_cur.dac1 = sampleData;  // see [RULE18]
        end else begin
          nxt_cur.dac0 = sampleData;  // see [RULE18]
        end
      end else if (channelSel) begin
        nxt_cur.latch1     = sampleData;  // see [RULE19]
        nxt_cur.latchPend1 = 1'b1;
      end else begin
        nxt_cur.latch0     = sampleData;  // see [RULE19]
        nxt_cur.latchPend0 = 1'b1;
      end
    end

    // Triggered latch transfer, independent of the FIFO run state.
    if (cfg.posted && trigHit) begin
      // A latch write in the trigger cycle stays pending, so the set wins over the clear.
      if (cur_ff.latchPend0) begin
        nxt_cur.dac0       = cur_ff.latch0;  // see [RULE19]
        nxt_cur.latchPend0 = latchWrite && !channelSel;
      end
      if (cur_ff.latchPend1) begin
        nxt_cur.dac1       = cur_ff.latch1;
        nxt_cur.latchPend1 = latchWrite && channelSel;
      end
    end

    unique case (cur_ff.st)
      ST_IDLE: begin
        if (start && !cur_ff.stat.waveformError) begin  // see [RULE20]
          nxt_cur.st   = ST_RUN;
          nxt_cur.pos  = 12'h000;
          nxt_cur.retx = 16'h0000;
          nxt_cur.stat.sequenceDone = 1'b0;
        end
      end
      ST_RUN: begin
        if (cfg.posted && trigHit) begin  // see [RULE1]
          if (cur_ff.level == 12'h000) begin
            nxt_cur.st                 = ST_IDLE;  // see [RULE8]
            nxt_cur.stat.waveformError = 1'b1;
          end else begin
            if (rdWord[DWS_DATA_W]) begin
              nxt_cur.dac1 = rdWord[DWS_DATA_W-1:0];  // see [RULE5]
            end else begin
              nxt_cur.dac0 = rdWord[DWS_DATA_W-1:0];
            end
            if (!cyclic) begin
              nxt_cur.rdPtr = cur_ff.rdPtr + 1'b1;  // see [RULE6]
              nxt_cur.level = cur_ff.level - 1'b1 + (doWrite ? 12'h001 : 12'h000);
            end else if (cur_ff.pos + 1'b1 == cur_ff.stored) begin
              // Rewinding keeps the data; the pointer returns to the first sample.
              nxt_cur.rdPtr    = cur_ff.rdPtr - cur_ff.pos[DWS_ADDR_W-1:0];  // see [RULE9]
              nxt_cur.pos      = 12'h000;
              nxt_cur.rewind_n = 1'b0;
              nxt_cur.retx     = cur_ff.retx + 1'b1;
              if (cfg.graceful_stop_bit) begin
                nxt_cur.st                = ST_DONE;  // see [RULE11]
                nxt_cur.stat.sequenceDone = 1'b1;  // see [RULE14]
              end else if (cfg.mode == MODE_PROG && cur_ff.retx + 1'b1 >= cfg.burstCount) begin
                nxt_cur.st                = ST_DONE;  // see [RULE13]
                nxt_cur.stat.sequenceDone = 1'b1;
              end else if (cfg.mode == MODE_PULSED && cur_ff.retx + 1'b1 >= cfg.burstCount) begin
                nxt_cur.st   = ST_GAP;  // see [RULE15]
                nxt_cur.gap  = 16'h0000;
                nxt_cur.retx = 16'h0000;
              end
              // Otherwise replay continues while the trigger stays enabled.  see [RULE10]
            end else begin
              nxt_cur.rdPtr = cur_ff.rdPtr + 1'b1;  // see [RULE7]
              nxt_cur.pos   = cur_ff.pos + 1'b1;
            end
          end
        end
      end
      ST_GAP: begin
        if (cfg.graceful_stop_bit || !cfg.trigEnable) begin
          nxt_cur.st                = ST_DONE;  // see [RULE15]
          nxt_cur.stat.sequenceDone = 1'b1;
        end else if (cur_ff.gap + 1'b1 >= cfg.gapCycles) begin
          nxt_cur.st = ST_RUN;  // see [RULE15]
        end else begin
          nxt_cur.gap = cur_ff.gap + 1'b1;
        end
      end
      ST_DONE: begin
        if (start) begin
          nxt_cur.st                = ST_RUN;
          nxt_cur.pos               = 12'h000;
          nxt_cur.retx              = 16'h0000;
          nxt_cur.stat.sequenceDone = 1'b0;
        end
      end
    endcase

    // Level bookkeeping for writes not already folded in above.
    if (doWrite && !(cur_ff.st == ST_RUN && cfg.posted && trigHit && !cyclic && cur_ff.level != 12'h000)) begin
      nxt_cur.level = cur_ff.level + 1'b1;
    end
    if (doWrite && cur_ff.st == ST_IDLE) begin
      nxt_cur.stored = cur_ff.stored + 1'b1;
    end

    // Set wins over clear for the error flag.
    if (clearError && !(nxt_cur.stat.waveformError && !cur_ff.stat.waveformError)) begin
      nxt_cur.stat.waveformError = 1'b0;  // see [RULE20]
    end

    if (fifoReset) begin
      nxt_cur.wrPtr  = 11'h000;
      nxt_cur.rdPtr  = 11'h000;
      nxt_cur.level  = 12'h000;
      nxt_cur.stored = 12'h000;
      nxt_cur.pos    = 12'h000;
      nxt_cur.st     = ST_IDLE;
    end

    nxt_cur.stat.fifoLevel = nxt_cur.level;
    nxt_cur.stat.fifoEmpty = (nxt_cur.level == 12'h000);
    nxt_cur.stat.fifoFull  = (nxt_cur.level == DWS_FULL);
    // Cyclic runs make no further requests once started.
    nxt_cur.stat.sample_write_request = cfg.posted && !(cyclic && nxt_cur.st != ST_IDLE) &&
      (cfg.halfFullReq ? (nxt_cur.level < DWS_HALF) : (nxt_cur.level != DWS_FULL));  // see [RULE3] [RULE4]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_ff          <= '0;
      cur_ff.dac0     <= DWS_DAC_RST;
      cur_ff.dac1     <= DWS_DAC_RST;
      cur_ff.rewind_n <= 1'b1;
      cur_ff.stat.fifoEmpty <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dacCode0            = cur_ff.dac0;
  assign dacCode1            = cur_ff.dac1;
  assign fifo_rewind_pulse_n = cur_ff.rewind_n;
  assign status              = cur_ff.stat;

endmodule

// [tb/dws_checker.sv]
// Port assertions of the waveform sequencer.
`timescale 1ns/10ps
module dws_checker
  import dws_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // Inputs
  input wire dws_cfg_t              cfg,
  input wire logic                  start,
  input wire logic                  clearError,
  input wire logic                  fifoReset,
  input wire logic                  latchWrite,
  input wire logic                  channelSel,
  input wire logic [DWS_DATA_W-1:0] sampleData,
  // Outputs
  input wire logic [DWS_DATA_W-1:0] dacCode0,
  input wire logic [DWS_DATA_W-1:0] dacCode1,
  input wire logic                  fifo_rewind_pulse_n,
  input wire dws_stat_t             status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rewind_one_cycle: assert property ($fell(fifo_rewind_pulse_n) |=> fifo_rewind_pulse_n)
    else $error("rewind pulse too long");
  a_immediate_latch_path: assert property (!cfg.posted && latchWrite && !channelSel |=> dacCode0 == $past(sampleData))
    else $error("immediate write not applied");
  a_posted_hold: assert property (cfg.posted && !cfg.trigEnable |=> $stable(dacCode0) && $stable(dacCode1))
    else $error("output moved without trigger");
  a_error_sticky: assert property (status.waveformError && !clearError |=> status.waveformError)
    else $error("error flag dropped");
  // The level that caused the error is the one shown a cycle earlier; a write may land beside it.
  a_error_on_empty: assert property ($rose(status.waveformError) |-> $past(status.fifoEmpty))
    else $error("error without underflow");
  a_full_no_request: assert property (status.fifoFull |-> !status.sample_write_request)
    else $error("request while full");
  a_level_bound: assert property (status.fifoLevel <= DWS_FULL)
    else $error("level above capacity");
  a_done_holds: assert property (status.sequenceDone && !start && !fifoReset |=> status.sequenceDone)
    else $error("done flag dropped");
endmodule

// [tb/dws_host_model.sv]
// Host model that answers sample requests with FIFO writes.
`timescale 1ns/10ps
module dws_host_model
  import dws_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // Control and request
  input wire logic              enable,
  input wire logic              slow,
  input wire logic              request,
  // Sample write
  output logic                  fifoWrite,
  output logic                  channelSel,
  output logic [DWS_DATA_W-1:0] sampleData
);
  logic [1:0]            waitCnt;
  logic [DWS_DATA_W-1:0] nextVal;
  // One idle cycle between writes (three when slow), so each request is seen after the last write landed.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fifoWrite <= 1'b0;
      sampleData <= 16'h0000;
      nextVal <= 16'h1000;
      waitCnt <= 2'h0;
    end else if (enable && request && !fifoWrite && (!slow || waitCnt == 2'h3)) begin
      fifoWrite <= 1'b1;
      sampleData <= nextVal;
      channelSel <= nextVal[0];
      nextVal <= nextVal + 16'h0001;
      waitCnt <= 2'h0;
    end else begin
      fifoWrite <= 1'b0;
      sampleData <= ~sampleData;
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule

// [tb/dws_sequencer_bench.sv]
// Self-checking bench of the waveform sequencer.
`timescale 1ns/10ps
module dws_sequencer_bench
  import dws_pkg::*;
;
  logic                  clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, clearError = 1'b0, fifoReset = 1'b0;
  logic                  updateStrobe = 1'b0, latchWrite = 1'b0, tWr = 1'b0, tCh = 1'b0, hostOn = 1'b0;
  logic                  slow = 1'b0, external_update_trigger_n = 1'b1, expErr = 1'b0, cyc = 1'b0;
  logic [3:0]            counterPulse_n = 4'hF;
  logic [DWS_DATA_W-1:0] tData = 16'h0000, d, hData, sampleData, dacCode0, dacCode1;
  logic [DWS_DATA_W-1:0] expDac [2] = '{16'h0000, 16'h0000};
  logic                  hWr, hCh, fifoWrite, channelSel, fifo_rewind_pulse_n;
  dws_cfg_t              cfg = '0;
  dws_stat_t             status;
  logic [16:0]           q[$];
  logic [31:0]           seed = 32'h57DE;
  int                    n_errors = 0, n_tests = 0, nRew = 0, expRew = 0, pos = 0, nBuf = 1;
  assign fifoWrite = hostOn ? hWr : tWr;
  assign channelSel = hostOn ? hCh : tCh;
  assign sampleData = hostOn ? hData : tData;
  initial forever #20 clk_sys = ~clk_sys;
  dws_sequencer dut (.clk_sys, .rst_n, .cfg, .start, .clearError, .fifoReset, .counterPulse_n,
    .external_update_trigger_n, .updateStrobe, .fifoWrite, .latchWrite, .channelSel, .sampleData,
    .dacCode0, .dacCode1, .fifo_rewind_pulse_n, .status);
  dws_host_model u_host (.clk_sys, .rst_n, .enable(hostOn), .slow, .request(status.sample_write_request),
    .fifoWrite(hWr), .channelSel(hCh), .sampleData(hData));
  always @(posedge clk_sys) begin
    if (rst_n && fifoWrite) q.push_back({channelSel, sampleData});
    if (rst_n && !fifo_rewind_pulse_n) nRew++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bad(input string m);
    n_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk_dac();
    n_tests++;
    if (dacCode0 !== expDac[0] || dacCode1 !== expDac[1]) bad("dac code");
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) bad("status flag");
  endtask
  task automatic chk_val(input logic [DWS_CNT_W-1:0] got, input logic [DWS_CNT_W-1:0] exp);
    n_tests++;
    if (got !== exp) bad("count");
  endtask
  // Trigger, then the model pops one entry when live; cyclic modes rotate it back in.
  task automatic trig(input bit live);
    logic [16:0] e;
    @(posedge clk_sys);
    case (cfg.trigSel)
      TRIG_EXT: external_update_trigger_n <= 1'b0;
      TRIG_REG: updateStrobe <= 1'b1;
      default: counterPulse_n[cfg.trigSel[1:0]] <= 1'b0;
    endcase
    @(posedge clk_sys);
    counterPulse_n <= 4'hF;
    external_update_trigger_n <= 1'b1;
    updateStrobe <= 1'b0;
    @(posedge clk_sys);
    #1;
    if (live && q.size() == 0) expErr = 1'b1;
    else if (live) begin
      e = q.pop_front();
      expDac[e[16]] = e[15:0];
      if (cyc) q.push_back(e);
      pos = (pos + 1) % nBuf;
      if (cyc && pos == 0) expRew++;
    end
    chk_dac();
    chk_flag(status.waveformError, expErr);
  endtask
  // Lets a new request condition reach the registered flag before waiting on it.
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 5000 && status.sample_write_request !== 1'b0; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    #1;
    chk_flag(status.sample_write_request, 1'b0);
  endtask
  task automatic latch(input logic ch);
    @(posedge clk_sys);
    d = 16'(rnd());
    latchWrite <= 1'b1;
    tCh <= ch;
    tData <= d;
    @(posedge clk_sys);
    latchWrite <= 1'b0;
  endtask
  task automatic load(input int n);
    @(posedge clk_sys);
    fifoReset <= 1'b1;
    @(posedge clk_sys);
    fifoReset <= 1'b0;
    q.delete();
    nBuf = n;
    pos = 0;
    cyc = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      tWr <= 1'b1;
      tData <= 16'(rnd());
      tCh <= i[0];
      @(posedge clk_sys);
      tWr <= 1'b0;
    end
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (11) @(posedge clk_sys);
    #1;
    chk_dac();
    chk_flag(status.fifoEmpty & fifo_rewind_pulse_n & !status.sample_write_request, 1'b1);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    cfg.trigEnable <= 1'b1;
    cfg.trigSel <= TRIG_REG;
    for (int c = 0; c < 2; c++) begin
      latch(c[0]);
      expDac[c] = d;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk_dac();
    @(posedge clk_sys);
    cfg.posted <= 1'b1;
    latch(1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_dac();
    expDac[0] = d;
    trig(0);
    @(posedge clk_sys);
    cfg.halfFullReq <= 1'b1;
    start <= 1'b1;
    hostOn <= 1'b1;
    slow <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    settle();
    chk_val(status.fifoLevel, DWS_HALF);
    @(posedge clk_sys);
    cfg.halfFullReq <= 1'b0;
    slow <= 1'b0;
    settle();
    chk_val(status.fifoLevel, DWS_FULL);
    chk_flag(status.fifoFull, 1'b1);
    for (int s = 0; s < 6; s++) begin
      @(posedge clk_sys);
      cfg.trigSel <= dws_trig_t'(s);
      settle();
      trig(1);
      chk_flag(status.sample_write_request, 1'b1);
    end
    @(posedge clk_sys);
    hostOn <= 1'b0;
    cfg.trigSel <= TRIG_REG;
    while (q.size() > 0) trig(1);
    repeat (2) trig(1);
    @(posedge clk_sys);
    clearError <= 1'b1;
    @(posedge clk_sys);
    clearError <= 1'b0;
    expErr = 1'b0;
    cfg.mode <= MODE_CYCLIC;
    load(5);
    repeat (12) trig(1);
    chk_flag(status.sample_write_request, 1'b0);
    @(posedge clk_sys);
    cfg.graceful_stop_bit <= 1'b1;
    repeat (3) trig(1);
    repeat (2) trig(0);
    @(posedge clk_sys);
    cfg.mode <= MODE_PROG;
    cfg.graceful_stop_bit <= 1'b0;
    cfg.burstCount <= 16'h0002;
    load(3);
    repeat (6) trig(1);
    repeat (2) trig(0);
    chk_flag(status.sequenceDone, 1'b1);
    @(posedge clk_sys);
    cfg.mode <= MODE_PULSED;
    cfg.burstCount <= 16'h0001;
    cfg.gapCycles <= 16'h0004;
    load(3);
    repeat (3) trig(1);
    repeat (8) @(posedge clk_sys);
    repeat (3) trig(1);
    @(posedge clk_sys);
    cfg.trigEnable <= 1'b0;
    repeat (2) trig(0);
    chk_val(12'(nRew), 12'(expRew));
    wrap_up();
  end
endmodule
bind dws_sequencer dws_checker u_chk (.clk_sys, .rst_n, .cfg, .start, .clearError, .fifoReset, .latchWrite,
  .channelSel, .sampleData, .dacCode0, .dacCode1, .fifo_rewind_pulse_n, .status);
